// ===== logic/tws_slave.sv
// two-wire bus slave with 256-byte store, page writes and axi4-lite view
// assumes pins asynchronous to clk_sys_in; master drives scl
// Overview of operation
// [RQ1] master acks every read byte but the last, may nack the last
// [RQ2] master alone makes clock pulses, start and stop; slave never drives scl
// [RQ3] transfer ends at stop or repeated start; repeated start opens next transfer
// [RQ4] receiver mode: slave acks each complete byte from master; data bytes past the 16 the buffer holds per transfer are nacked
// [RQ5] start begins a transfer and stop ends it in both modes
// [RQ6] address match is judged only after all eight control bits arrive
// [RQ7] read direction: slave shifts data out on sda, timed by master scl
// [RQ8] first byte after start is control; upper six bits must be 101000
// [RQ9] select bit must equal the address select pin level
// [RQ10] control byte bit zero set selects read, clear selects write
// [RQ11] on matching control byte the slave drives an acknowledge
// [RQ12] wiper store changes only while write protect is low
// [RQ13] write protect pulled high blocks stored wiper updates
// [RQ14] write: pointer byte then data, each acked; stop starts timed write
// [RQ15] page write up to eight bytes, wrapping within the eight-byte page
// [RQ16] no address ack while the internal write cycle runs
// [RQ17] pointer increments per byte; sequential reads wrap ffh to 00h
// [RQ18] mismatch: no ack, sda released, ignore bus until next start
// [RQ19] sda only pulled low, released unless acking or sending zero
`timescale 1ns/1ps
module tws_slave #(
   parameter int TW_NS = tws_pkg::TW_NS_DEF
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // two-wire bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // straps
   input wire logic wp_in,
   input wire logic address_select_pin_in,
   // axi4-lite write
   input wire logic [31:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // axi4-lite read
   input wire logic [31:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in
);
   localparam int TW_CYC_RAW = (TW_NS + tws_pkg::CLK_NS - 1) / tws_pkg::CLK_NS;
   localparam int TW_CYC = (TW_CYC_RAW < 1) ? 1 : TW_CYC_RAW;
   function automatic logic reg_hit(input logic [31:0] a);
      reg_hit = (a == tws_pkg::REG_CTRL) || (a == tws_pkg::REG_STATUS) ||
         (a == tws_pkg::REG_MEM_ADDR) || (a == tws_pkg::REG_MEM_DATA);
   endfunction : reg_hit
   // synchronised pins
   logic [3:0] pins_s;
   tws_sync #(.W(4)) u_sync (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .d_in({scl_in, sda_in, wp_in, address_select_pin_in}), .q_out(pins_s));
   wire scl_s = pins_s[3];
   wire sda_s = pins_s[2];
   wire wp_s = pins_s[1];
   wire asel_s = pins_s[0];
   // bus state
   tws_pkg::tws_state_e state;
   logic scl_q, sda_q, byte_done, rw, mack;
   logic [2:0] bitcnt;
   logic [1:0] byte_idx;
   logic [7:0] shreg, tx_sh, ptr;
   // store and write engine
   logic [7:0] mem [tws_pkg::MEM_DEPTH];
   logic busy, wr_pend;
   logic [31:0] tw_cnt;
   // registers
   logic lock, aw_got, w_got;
   logic [7:0] mem_addr;
   logic [31:0] aw_addr, w_data;
   logic [3:0] w_strb;
   // fifo
   logic fifo_in_ready, fifo_out_valid;
   logic [15:0] fifo_out_data;
   // bus conditions
   wire start_c = scl_s && scl_q && sda_q && !sda_s; // RQ5
   wire stop_c = scl_s && scl_q && !sda_q && sda_s; // RQ5
   wire scl_rise = scl_s && !scl_q;
   wire scl_fall = !scl_s && scl_q;
   wire eval = (state == tws_pkg::ST_RX) && scl_fall && byte_done && !start_c && !stop_c; // RQ6
   wire is_ctl = (byte_idx == tws_pkg::IDX_CTL);
   wire is_ptr = (byte_idx == tws_pkg::IDX_PTR);
   wire is_data = (byte_idx == tws_pkg::IDX_DATA);
   wire code_ok = (shreg[7:tws_pkg::CTL_CODE_LSB] == tws_pkg::CTL_CODE); // RQ8
   wire sel_ok = (shreg[tws_pkg::CTL_SEL_BIT] == asel_s); // RQ9
   wire ctl_ok = code_ok && sel_ok && !busy; // RQ11 RQ16
   wire ack_ok = is_ctl ? ctl_ok : (is_ptr || fifo_in_ready); // RQ4
   wire push_v = eval && is_data;
   wire push = push_v && fifo_in_ready;
   wire [7:0] ptr_pg = {ptr[7:tws_pkg::PAGE_BITS],
      ptr[tws_pkg::PAGE_BITS-1:0] + tws_pkg::PAGE_BITS'(1)}; // RQ15
   wire [7:0] mem_rd = mem[ptr];
   wire tx_load = !start_c && !stop_c && scl_fall &&
      (((state == tws_pkg::ST_ACK) && rw) || ((state == tws_pkg::ST_RACK) && !mack));
   wire mem_we = busy && fifo_out_valid && !wp_s && !lock; // RQ12 RQ13
   wire fifo_out_ready = busy;
   tws_fifo #(.W(tws_pkg::FIFO_W), .D(tws_pkg::FIFO_D)) u_fifo (.clk_sys_in(clk_sys_in),
      .rst_in(rst_in), .in_valid_in(push_v), .in_ready_out(fifo_in_ready),
      .in_data_in({ptr, shreg}), .out_valid_out(fifo_out_valid),
      .out_ready_in(fifo_out_ready), .out_data_out(fifo_out_data));
   // bus engine
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state <= tws_pkg::ST_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         bitcnt <= 3'h0;
         byte_done <= 1'b0;
         byte_idx <= tws_pkg::IDX_CTL;
         shreg <= 8'h00;
         tx_sh <= 8'h00;
         ptr <= 8'h00;
         rw <= 1'b0;
         mack <= 1'b1;
         sda_oe_out <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         sda_out <= 1'b0; // RQ19
         if (start_c) begin // RQ3 RQ5
            state <= tws_pkg::ST_RX;
            bitcnt <= 3'h0;
            byte_done <= 1'b0;
            byte_idx <= tws_pkg::IDX_CTL;
            sda_oe_out <= 1'b0;
         end else if (stop_c) begin // RQ5
            state <= tws_pkg::ST_IDLE;
            sda_oe_out <= 1'b0;
         end else begin
            case (state)
               tws_pkg::ST_RX: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_s};
                     bitcnt <= bitcnt + 3'h1;
                     byte_done <= (bitcnt == tws_pkg::BIT_LAST);
                  end else if (eval) begin
                     byte_done <= 1'b0;
                     if (ack_ok) begin
                        state <= tws_pkg::ST_ACK;
                        sda_oe_out <= 1'b1; // RQ4 RQ11
                     end else begin
                        state <= tws_pkg::ST_IGN; // RQ18
                     end
                     if (!is_data) begin
                        byte_idx <= byte_idx + 2'h1;
                     end
                     if (is_ctl) begin
                        rw <= shreg[tws_pkg::CTL_RW_BIT]; // RQ10
                     end
                     if (is_ptr) begin
                        ptr <= shreg; // RQ14
                     end
                     if (push) begin
                        ptr <= ptr_pg; // RQ15
                     end
                  end
               end
               tws_pkg::ST_ACK: begin
                  if (scl_fall && !rw) begin
                     state <= tws_pkg::ST_RX;
                     bitcnt <= 3'h0;
                     sda_oe_out <= 1'b0; // RQ19
                  end
               end
               tws_pkg::ST_TX: begin
                  if (scl_fall) begin // RQ7
                     bitcnt <= bitcnt + 3'h1;
                     if (bitcnt == tws_pkg::BIT_LAST) begin
                        state <= tws_pkg::ST_RACK;
                        sda_oe_out <= 1'b0; // RQ19
                     end else begin
                        tx_sh <= {tx_sh[6:0], 1'b0};
                        sda_oe_out <= !tx_sh[6];
                     end
                  end
               end
               tws_pkg::ST_RACK: begin
                  if (scl_rise) begin
                     mack <= sda_s;
                  end else if (scl_fall && mack) begin
                     state <= tws_pkg::ST_IGN;
                  end
               end
               default: ;
            endcase
            if (tx_load) begin // RQ7 RQ17
               state <= tws_pkg::ST_TX;
               tx_sh <= mem_rd;
               ptr <= ptr + 8'h01;
               sda_oe_out <= !mem_rd[7];
               bitcnt <= 3'h0;
               mack <= 1'b1;
            end
         end
      end
   end
   // store writes from the buffer, gated by write protect
   always_ff @(posedge clk_sys_in) begin
      if (mem_we) begin
         mem[fifo_out_data[15:8]] <= fifo_out_data[7:0]; // RQ12 RQ13
      end
   end
   // internal write cycle after stop
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         busy <= 1'b0;
         wr_pend <= 1'b0;
         tw_cnt <= 32'h0000_0000;
      end else begin
         if (stop_c && wr_pend && !busy) begin // RQ14
            busy <= 1'b1;
            wr_pend <= 1'b0;
            tw_cnt <= 32'h0000_0000;
         end else if (push) begin
            wr_pend <= 1'b1;
         end
         if (busy && !fifo_out_valid) begin
            if (tw_cnt == 32'(TW_CYC - 1)) begin
               busy <= 1'b0;
            end else begin
               tw_cnt <= tw_cnt + 32'h0000_0001;
            end
         end
      end
   end

   // register decode
   wire aw_hit = reg_hit(aw_addr);
   wire ar_hit = reg_hit(s_axi_araddr_in);
   wire wr_ctrl = aw_got && w_got && !s_axi_bvalid_out && (aw_addr == tws_pkg::REG_CTRL);
   wire wr_madr = aw_got && w_got && !s_axi_bvalid_out && (aw_addr == tws_pkg::REG_MEM_ADDR);
   wire [31:0] status_w = (32'(busy) << tws_pkg::ST_BUSY) | (32'(wp_s) << tws_pkg::ST_WP) |
      (32'(asel_s) << tws_pkg::ST_ASEL) | (32'(ptr) << tws_pkg::ST_PTR) |
      (32'(state) << tws_pkg::ST_STATE);
   wire [31:0] rd_mux =
      (s_axi_araddr_in == tws_pkg::REG_CTRL) ? (32'(lock) << tws_pkg::CTRL_LOCK) :
      (s_axi_araddr_in == tws_pkg::REG_STATUS) ? status_w :
      (s_axi_araddr_in == tws_pkg::REG_MEM_ADDR) ? 32'(mem_addr) :
      (s_axi_araddr_in == tws_pkg::REG_MEM_DATA) ? 32'(mem[mem_addr]) : 32'h0000_0000;

   // axi write channel
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_awready_out <= 1'b1;
         s_axi_wready_out <= 1'b1;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= tws_pkg::RESP_OKAY;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 32'h0000_0000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         lock <= 1'b0;
         mem_addr <= 8'h00;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_got <= 1'b1;
            s_axi_awready_out <= 1'b0;
            aw_addr <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_got <= 1'b1;
            s_axi_wready_out <= 1'b0;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end
         if (aw_got && w_got && !s_axi_bvalid_out) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= aw_hit ? tws_pkg::RESP_OKAY : tws_pkg::RESP_SLVERR;
         end
         if (wr_ctrl && w_strb[0]) begin
            lock <= w_data[tws_pkg::CTRL_LOCK];
         end
         if (wr_madr && w_strb[0]) begin
            mem_addr <= w_data[7:0];
         end
         if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
         end
      end
   end

   // axi read channel
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= tws_pkg::RESP_OKAY;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= rd_mux;
         s_axi_rresp_out <= ar_hit ? tws_pkg::RESP_OKAY : tws_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_arready_out <= 1'b1;
      end
   end

   // checks
   chk_start_opens_rx: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RQ5
      start_c |=> (state == tws_pkg::ST_RX) && (bitcnt == 3'h0) && !sda_oe_out)
      else $error("start did not open a receive byte");
   chk_stop_to_idle: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RQ5
      (stop_c && !start_c) |=> (state == tws_pkg::ST_IDLE) && !sda_oe_out)
      else $error("stop did not end the transfer");
   chk_eight_bits_first: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RQ6
      (state == tws_pkg::ST_RX && scl_fall && !byte_done && !start_c && !stop_c)
      |=> state == tws_pkg::ST_RX)
      else $error("byte judged before eight bits");
   chk_ctl_match_ack: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RQ11
      (eval && is_ctl && ctl_ok) |=> (state == tws_pkg::ST_ACK) && sda_oe_out &&
      (rw == $past(shreg[tws_pkg::CTL_RW_BIT])))
      else $error("matching control byte not acknowledged");
   chk_mismatch_ignore: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RQ18
      (eval && is_ctl && !(code_ok && sel_ok)) |=> (state == tws_pkg::ST_IGN) && !sda_oe_out)
      else $error("mismatched control byte was answered");
   chk_busy_no_ack: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RQ16
      (eval && is_ctl && busy) |=> !sda_oe_out ##1 !sda_oe_out)
      else $error("address acknowledged during write cycle");
   chk_ack_holds_low: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RQ4
      (state == tws_pkg::ST_ACK) |-> sda_oe_out)
      else $error("sda released during acknowledge");
   chk_rack_released: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RQ19
      (state == tws_pkg::ST_RACK || state == tws_pkg::ST_IGN || state == tws_pkg::ST_IDLE)
      |-> !sda_oe_out && !sda_out)
      else $error("sda driven outside ack or zero bit");
   chk_wp_blocks: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RQ13
      (wp_s || lock) |-> !mem_we)
      else $error("store written while protected");
   chk_page_wrap: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RQ15
      (push && ptr[tws_pkg::PAGE_BITS-1:0] == '1) |=>
      (ptr[tws_pkg::PAGE_BITS-1:0] == '0) && (ptr[7:tws_pkg::PAGE_BITS] ==
      $past(ptr[7:tws_pkg::PAGE_BITS])))
      else $error("page pointer did not wrap");
   chk_seq_wrap: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RQ17
      (tx_load && ptr == 8'hFF) |=> ptr == 8'h00)
      else $error("read pointer did not wrap");
   cov_write_byte: cover property (@(posedge clk_sys_in) disable iff (rst_in) push ##[1:1000] busy);
   cov_read_byte: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      tx_load ##[1:1000] state == tws_pkg::ST_RACK);
   cov_rstart: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      (state == tws_pkg::ST_RX && byte_idx == tws_pkg::IDX_DATA) ##1 start_c);
endmodule : tws_slave

// ===== logic/tws_pkg.sv
// constants, register map and state encoding for the two-wire slave
// assumes a 100 MHz system clock and an axi4-lite register port
package tws_pkg;
   localparam int CLK_NS = 10;
   // internal write cycle length in ns, arbitrary plain default
   localparam int TW_NS_DEF = 10000000;
   // control byte layout
   localparam logic [5:0] CTL_CODE = 6'h28;
   localparam int CTL_CODE_LSB = 2;
   localparam int CTL_SEL_BIT = 1;
   localparam int CTL_RW_BIT = 0;
   // byte position within a transfer
   localparam logic [1:0] IDX_CTL = 2'h0;
   localparam logic [1:0] IDX_PTR = 2'h1;
   localparam logic [1:0] IDX_DATA = 2'h2;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam int PAGE_BITS = 3;
   localparam int MEM_DEPTH = 256;
   // data buffer
   localparam int FIFO_W = 16;
   localparam int FIFO_D = 16;
   // register byte addresses
   localparam logic [31:0] REG_CTRL = 32'h0000_0000;
   localparam logic [31:0] REG_STATUS = 32'h0000_0004;
   localparam logic [31:0] REG_MEM_ADDR = 32'h0000_0008;
   localparam logic [31:0] REG_MEM_DATA = 32'h0000_000C;
   localparam int CTRL_LOCK = 0;
   localparam int ST_BUSY = 0;
   localparam int ST_WP = 1;
   localparam int ST_ASEL = 2;
   localparam int ST_PTR = 8;
   localparam int ST_STATE = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // gray along idle, rx, ack, tx, master-ack
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RX = 3'h1,
      ST_ACK = 3'h3,
      ST_TX = 3'h2,
      ST_RACK = 3'h6,
      ST_IGN = 3'h7
   } tws_state_e;
endpackage : tws_pkg

// ===== logic/tws_sync.sv
// two-flop synchroniser for pin levels
// assumes inputs are asynchronous to clk_sys_in
`timescale 1ns/1ps
module tws_sync #(
   parameter int W = 4
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // levels
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         meta <= '1;
         q_out <= '1;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end
endmodule : tws_sync

// ===== logic/tws_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes one clock; depth is a power of two
`timescale 1ns/1ps
module tws_fifo #(
   parameter int W = 16,
   parameter int D = 16
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wptr;
   logic [AW:0] rptr;
   wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
   wire empty = (wptr == rptr);
   wire do_push = in_valid_in && !full;
   wire do_pop = out_ready_in && !empty;

   assign in_ready_out = !full;
   assign out_valid_out = !empty;
   assign out_data_out = mem[rptr[AW-1:0]];

   always_ff @(posedge clk_sys_in) begin
      if (do_push) begin
         mem[wptr[AW-1:0]] <= in_data_in;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wptr <= '0;
         rptr <= '0;
      end else begin
         if (do_push) begin
            wptr <= wptr + 1'b1;
         end
         if (do_pop) begin
            rptr <= rptr + 1'b1;
         end
      end
   end
endmodule : tws_fifo

// ===== bench/tws_master.sv
// behavioural two-wire bus master driving scl and its share of sda
// assumes the bench resolves sda from this drive and the slave's enable
`timescale 1ns/1ps
module tws_master (
   // clock
   input wire logic clk_sys_in,
   // two-wire bus
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic hc;
      repeat (10) @(posedge clk_sys_in);
   endtask : hc
   task automatic bit_io(input logic b, output logic r);
      sda_out <= b;
      hc();
      scl_out <= 1'b1;
      hc();
      r = sda_in;
      scl_out <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
   endtask : bit_io
   task automatic start;
      sda_out <= 1'b1;
      hc();
      scl_out <= 1'b1;
      hc();
      sda_out <= 1'b0;
      hc();
      scl_out <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
   endtask : start
   task automatic stop;
      sda_out <= 1'b0;
      hc();
      scl_out <= 1'b1;
      hc();
      sda_out <= 1'b1;
      hc();
   endtask : stop
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask : wbyte
   task automatic rbyte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         b[i] = r;
      end
      bit_io(last, r);
   endtask : rbyte
endmodule : tws_master

// ===== bench/tb_top.sv
// self-checking bench: two-wire master model plus axi4-lite register master
// assumes slave write cycle shortened to 500 clocks
`timescale 1ns/1ps
module tb_top;
   logic clk_sys_in, rst_in, wp, asel, awvalid, wvalid, bready, arvalid, rready, ack;
   logic [31:0] awaddr, wdata, araddr, d, seed;
   logic [1:0] rs;
   logic [7:0] b, ptr, mem [256];
   wire logic awready, wready, bvalid, arready, rvalid, sda_oe, sda_o, scl, sda_m;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic sda = sda_m & (sda_oe ? sda_o : 1'b1);
   int n_fail, cmp_count, cyc;
   tws_slave #(.TW_NS(5000)) tws_slave_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .wp_in(wp),
      .address_select_pin_in(asel), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
      .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
      .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
   tws_master tws_master_i (.clk_sys_in(clk_sys_in), .sda_in(sda), .scl_out(scl),
      .sda_out(sda_m));
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   function automatic logic exp_ack(input logic [5:0] code, input logic sel, input logic busy);
      return code == tws_pkg::CTL_CODE && sel == asel && !busy;
   endfunction : exp_ack
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic conclude;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         conclude();
      end
   end
   task automatic axw(input logic [31:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge clk_sys_in);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         rs = bresp;
         @(posedge clk_sys_in);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!tb);
   endtask : axw
   task automatic axr(input logic [31:0] a);
      logic ta, tr;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk_sys_in);
         ta = arvalid & arready;
         tr = rvalid;
         d = rdata;
         rs = rresp;
         @(posedge clk_sys_in);
         if (ta) arvalid <= 1'b0;
      end while (!tr);
   endtask : axr
   task automatic ctl_chk(input logic [5:0] code, input logic sel, input logic rw,
      input logic busy);
      tws_master_i.start();
      tws_master_i.wbyte({code, sel, rw}, ack);
      chk(ack, exp_ack(code, sel, busy), "ctrl ack");
   endtask : ctl_chk
   task automatic wait_idle;
      do axr(tws_pkg::REG_STATUS); while (d[tws_pkg::ST_BUSY] !== 1'b0);
      chk(d[tws_pkg::ST_WP], wp, "status wp");
      chk(d[tws_pkg::ST_ASEL], asel, "status select");
   endtask : wait_idle
   task automatic rb(input logic [7:0] base, input int n);
      for (int j = 0; j < n; j++) begin
         axw(tws_pkg::REG_MEM_ADDR, {24'h0, base + 8'(j)});
         axr(tws_pkg::REG_MEM_DATA);
         chk(d[7:0], mem[base + 8'(j)], "stored byte");
      end
   endtask : rb
   initial begin
      {rst_in, wp, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
      {awaddr, wdata, araddr} = '0;
      {n_fail, cmp_count, cyc} = '0;
      seed = xs(32'h54EAB02E);
      asel = seed[0];
      repeat (20) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      axr(32'h0000_0010);
      chk(rs, tws_pkg::RESP_SLVERR, "unmapped resp");
      axw(tws_pkg::REG_CTRL, 32'h0);
      chk(rs, tws_pkg::RESP_OKAY, "ctrl resp");
      for (int k = 0; k < 2; k++) begin
         ctl_chk(k ? tws_pkg::CTL_CODE : 6'h2C, k ? ~asel : asel, 1'b0, 1'b0);
         tws_master_i.wbyte(8'h00, ack);
         chk(ack, 1'b0, "ignored byte");
         tws_master_i.stop();
      end
      for (int p = 0; p < 3; p++) begin
         ptr = p == 1 ? 8'h02 : p == 0 ? 8'hFD : 8'h00;
         wp <= p == 2;
         ctl_chk(tws_pkg::CTL_CODE, asel, 1'b0, 1'b0);
         tws_master_i.wbyte(ptr, ack);
         chk(ack, 1'b1, "pointer ack");
         for (int i = 0; i < (p == 2 ? 17 : 8); i++) begin
            seed = xs(seed);
            if (p < 2) mem[{ptr[7:3], ptr[2:0] + 3'(i)}] = seed[7:0];
            tws_master_i.wbyte(seed[7:0], ack);
            chk(ack, i < 16, "data ack");
         end
         tws_master_i.stop();
         ctl_chk(tws_pkg::CTL_CODE, asel, 1'b0, 1'b1);
         tws_master_i.stop();
         wait_idle();
      end
      rb(8'hF8, 16);
      wp <= 1'b0;
      axw(tws_pkg::REG_CTRL, 32'h1);
      axr(tws_pkg::REG_CTRL);
      chk(d, 32'h1, "lock readback");
      ctl_chk(tws_pkg::CTL_CODE, asel, 1'b0, 1'b0);
      tws_master_i.wbyte(8'h00, ack);
      tws_master_i.wbyte(~mem[0], ack);
      chk(ack, 1'b1, "locked data ack");
      tws_master_i.stop();
      wait_idle();
      axw(tws_pkg::REG_CTRL, 32'h0);
      rb(8'h00, 1);
      ctl_chk(tws_pkg::CTL_CODE, asel, 1'b0, 1'b0);
      tws_master_i.wbyte(8'hFC, ack);
      chk(ack, 1'b1, "pointer ack");
      ctl_chk(tws_pkg::CTL_CODE, asel, 1'b1, 1'b0);
      for (int i = 0; i < 8; i++) begin
         tws_master_i.rbyte(i == 7, b);
         chk(b, mem[8'hFC + 8'(i)], "read byte");
      end
      chk(sda_o, 1'b0, "sda drive level");
      tws_master_i.stop();
      conclude();
   end
endmodule : tb_top
